// file: bench/fault_and_sleep_supervisor_test.sv
// Self-checking bench of the fault and sleep supervisor
// ********************
// Bench
// ********************
module fault_and_sleep_supervisor_test;
   timeunit 1ns;
   timeprecision 1ps;
   import fss_pkg::*;
   logic core_clk_in;
   logic rst_n_in;
   fss_det_s det;
   fss_drv_s drv;
   logic sleep_n;
   logic oe;
   logic od;
   logic pin;
   int miscompares = 0;
   int total_checks = 0;
   int cyc = 0;
   always #5 core_clk_in = ~core_clk_in;
   fss_mcu_model fss_mcu_model_inst (.clk_in(core_clk_in), .oe_in(oe), .o_in(od),
      .sleep_low_out(sleep_n), .fault_pin_out(pin));
   fss_supervisor #(.SLEEP_ENTRY_CYC(14'h012C), .RST_MIN_CYC(14'h0014),
      .WAKE_CYC(14'h0004), .OCP_CYC(14'h0005)) fss_supervisor_inst (
      .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .sleep_ctl_low_in(sleep_n),
      .fault_indicator_low_in(pin), .fault_indicator_low_o_out(od),
      .fault_indicator_low_oe_out(oe), .det_in(det), .drv_out(drv));
   // Compare and count
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask
   // Outputs as bridges, pump, ldo, ready, oe, pin
   task automatic ex(input logic [6:0] e);
      chk({1'b0, drv, oe, pin}, {1'b0, e});
   endtask
   task automatic wait_ready();
      int n = 0;
      while (drv.ready !== 1'b1 && n < 50)
      begin
         step(1);
         n++;
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Lockouts recover by themselves
   task automatic t_lockouts();
      det.supply_low = 1'b1;
      step(3);
      ex(7'h0A);
      det.supply_low = 1'b0;
      step(10);
      wait_ready();
      ex(7'h7D);
      det.pump_low = 1'b1;
      step(3);
      ex(7'h1E);
      det.pump_low = 1'b0;
      step(3);
      ex(7'h7D);
   endtask
   // Overcurrent latch, short pulse ignored, valid pulse clears
   task automatic t_ocp();
      det.ilimit[0] = 1'b1;
      step(10);
      ex(7'h5E);
      det.ilimit[0] = 1'b0;
      step(10);
      ex(7'h5E);
      fss_mcu_model_inst.pulse(10);
      step(8);
      ex(7'h5E);
      fss_mcu_model_inst.hold(1'b0);
      step(10);
      chk({5'h00, drv.bridge_en, drv.pump_en}, 8'h01);
      step(20);
      fss_mcu_model_inst.hold(1'b1);
      step(8);
      ex(7'h7D);
   endtask
   // Overtemperature clears only when cool
   task automatic t_hot();
      det.hot = 1'b1;
      det.cool = 1'b0;
      step(3);
      ex(7'h0E);
      det.hot = 1'b0;
      fss_mcu_model_inst.pulse(30);
      step(8);
      ex(7'h0E);
      det.cool = 1'b1;
      fss_mcu_model_inst.pulse(30);
      step(8);
      ex(7'h7D);
   endtask
   // Long low below sleep entry clears without shutdown
   task automatic t_mid();
      det.ilimit[1] = 1'b1;
      step(10);
      ex(7'h3E);
      det.ilimit[1] = 1'b0;
      fss_mcu_model_inst.hold(1'b0);
      step(100);
      chk({7'h00, drv.ldo_en}, 8'h01);
      fss_mcu_model_inst.hold(1'b1);
      step(8);
      ex(7'h7D);
   endtask
   // Sleep entry and wake with faults cleared
   task automatic t_sleep();
      det.ilimit[0] = 1'b1;
      step(10);
      det.ilimit[0] = 1'b0;
      fss_mcu_model_inst.hold(1'b0);
      step(310);
      chk({3'h0, drv}, 8'h00);
      fss_mcu_model_inst.hold(1'b1);
      wait_ready();
      step(2);
      ex(7'h7D);
   endtask
   // Main sequence
   initial
   begin
      core_clk_in = 1'b0;
      rst_n_in = 1'b0;
      det = '{supply_low: 1'b0, pump_low: 1'b0, ilimit: 2'h0, hot: 1'b0, cool: 1'b1};
      step(8);
      ex(7'h01);
      step(8);
      rst_n_in = 1'b1;
      wait_ready();
      step(2);
      ex(7'h7D);
      t_lockouts();
      t_ocp();
      t_hot();
      t_mid();
      t_sleep();
      end_sim();
   end
   // Hang guard
   always @(posedge core_clk_in)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         miscompares++;
         end_sim();
      end
   end
endmodule

// file: bench/fss_mcu_model.sv
// Controller model driving the sleep pin and reading the fault pin
// ********************
// Controller model
// ********************
module fss_mcu_model (
   // Pins
   input wire logic clk_in,
   input wire logic oe_in,
   input wire logic o_in,
   output logic sleep_low_out,
   output logic fault_pin_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pull-up on the open-drain fault line
   assign fault_pin_out = oe_in ? o_in : 1'b1;
   initial sleep_low_out = 1'b1;
   // Level on the sleep pin
   task automatic hold(input logic v);
      sleep_low_out = v;
   endtask
   // Low pulse of n cycles on the sleep pin
   task automatic pulse(input int n);
      sleep_low_out = 1'b0;
      repeat (n) @(posedge clk_in);
      #1 sleep_low_out = 1'b1;
   endtask
endmodule

// file: bench/fss_props.sv
// Port checker of the fault and sleep supervisor
// ********************
// Checker
// ********************
module fss_props #(
   parameter logic [13:0] OCP_CYC = 14'h0005
)
(
   // Watched ports
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic sleep_ctl_low_in,
   input wire logic fault_indicator_low_o_out,
   input wire logic fault_indicator_low_oe_out,
   input wire fss_pkg::fss_det_s det_in,
   input wire fss_pkg::fss_drv_s drv_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import fss_pkg::*;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   // Sleep pin held low for three samples
   sequence s_low3;
      !sleep_ctl_low_in [*3];
   endsequence
   // Current limit on bridge 0 beyond the filter
   sequence s_trip0;
      det_in.ilimit[0] [*8];
   endsequence
   a_supply_off: assert property (det_in.supply_low |=>
      drv_out.bridge_en == 2'b00 && !drv_out.pump_en && fault_indicator_low_oe_out)
      else $error("supply lockout not honoured");
   a_pump_low_off: assert property (det_in.pump_low |=>
      drv_out.bridge_en == 2'b00 && fault_indicator_low_oe_out)
      else $error("pump rail lockout not honoured");
   a_hot_off: assert property (det_in.hot |=>
      drv_out.bridge_en == 2'b00 && !drv_out.pump_en && fault_indicator_low_oe_out)
      else $error("overtemperature not honoured");
   a_open_drain: assert property (!fault_indicator_low_o_out)
      else $error("fault pin data not low");
   a_sleep_hiz: assert property (s_low3 |=> drv_out.bridge_en == 2'b00)
      else $error("bridge driven while sleep pin low");
   a_trip_bridge: assert property (s_trip0 |=> !drv_out.bridge_en[0])
      else $error("overcurrent did not disable bridge");
   // Two samples of a lone bridge 1 mark a settled latch, not the cycle after a clear
   a_trip_held: assert property (
      drv_out.bridge_en == 2'b10 && $past(drv_out.bridge_en) == 2'b10 && sleep_ctl_low_in
      |=> !drv_out.bridge_en[0])
      else $error("overcurrent latch lost");
   a_sleep_ldo: assert property (!drv_out.ldo_en |->
      !drv_out.pump_en && !drv_out.ready && drv_out.bridge_en == 2'b00)
      else $error("regulator off outside sleep");
endmodule

bind fss_supervisor fss_props #(.OCP_CYC(OCP_CYC)) fss_props_inst (.core_clk_in, .rst_n_in,
   .sleep_ctl_low_in, .fault_indicator_low_o_out, .fault_indicator_low_oe_out, .det_in,
   .drv_out);

// file: core/fss_consts.svh
// Timing and sizing constants for the fault and sleep supervisor
`ifndef FSS_CONSTS_SVH
`define FSS_CONSTS_SVH

// Core clock period
`define FSS_CLK_NS 10
// Counter width for every timebase counter
`define FSS_CNT_W 14
// Least low time of a fault-clear pulse
`define FSS_T_RST_MIN_NS 20000
// Low time after which sleep entry is definite
`define FSS_T_SLEEP_NS 120000
// Wake delay before the bridges accept inputs
`define FSS_T_WAKE_NS 1000
// Overcurrent filter time
`define FSS_T_OCP_NS 2000
// Least times round up to whole cycles
`define FSS_CYC_UP(ns) (((ns) + `FSS_CLK_NS - 1) / `FSS_CLK_NS)
`define FSS_RST_MIN_CYC `FSS_CYC_UP(`FSS_T_RST_MIN_NS)
`define FSS_SLEEP_CYC `FSS_CYC_UP(`FSS_T_SLEEP_NS)
`define FSS_WAKE_CYC `FSS_CYC_UP(`FSS_T_WAKE_NS)
`define FSS_OCP_CYC `FSS_CYC_UP(`FSS_T_OCP_NS)
// Counter constants
`define FSS_CNT_ZERO 14'h0000
`define FSS_CNT_ONE 14'h0001
`define FSS_CNT_MAX 14'h3FFF

`endif

// file: core/fss_pkg.sv
// Types shared by the fault and sleep supervisor
package fss_pkg;

   // Power state, Gray coded along sleep, wake, active
   typedef enum logic [1:0]
   {
      FSS_SLEEP  = 2'b00,
      FSS_WAKE   = 2'b01,
      FSS_ACTIVE = 2'b11
   } fss_state_e;

   // Analog detector levels
   typedef struct packed
   {
      logic supply_low;   // Motor supply below lockout
      logic pump_low;     // Pump rail below lockout
      logic [1:0] ilimit; // FET current limit active, per bridge
      logic hot;          // Die above shutdown limit
      logic cool;         // Die below limit minus hysteresis
   } fss_det_s;

   // Power stage controls
   typedef struct packed
   {
      logic [1:0] bridge_en; // Bridge driven when high, hi-Z when low
      logic pump_en;         // Charge pump running
      logic ldo_en;          // Logic regulator on
      logic ready;           // Wake delay over, inputs accepted
   } fss_drv_s;

endpackage

// file: core/fss_supervisor.sv
// Fault latching, sleep and fault-clear sequencing of a dual-bridge driver
`include "fss_consts.svh"

// Notes on behaviour
// - Supply lockout disables all bridges, pulls fault low, stops the pump.
// - Supply lockout recovers by itself once the supply returns.
// - Pump rail lockout disables bridges and pulls fault low; pump keeps running.
// - Pump rail lockout recovers by itself once the rail returns.
// - Current limit beyond filter time disables only that bridge and flags fault.
// - Overcurrent stays latched until a clear pulse, a supply lockout or a power cycle.
// - Overtemperature disables all bridges, pulls fault low, stops the pump.
// - Overtemperature clears only after a clear pulse once cooled, or on supply lockout.
// - Fault pin is open drain, low on any fault, released after power-up.
// - After the sleep input falls and the entry delay passes, enter sleep.
// - Sleep also switches the logic regulator off.
// - Sleep input high wakes; ready needs the active state, sleep high and supply good.
// - Low pulse over 20 us and under 40 us clears latched faults.
// - Low time 40 to 120 us clears faults; shutdown is not taken.
// - A clear pulse leaves the pump and other blocks as they were.
// - While the sleep input is low, every bridge output is hi-Z.
module fss_supervisor #(
   parameter logic [`FSS_CNT_W-1:0] SLEEP_ENTRY_CYC = `FSS_CNT_W'(`FSS_SLEEP_CYC),
   parameter logic [`FSS_CNT_W-1:0] RST_MIN_CYC = `FSS_CNT_W'(`FSS_RST_MIN_CYC),
   parameter logic [`FSS_CNT_W-1:0] WAKE_CYC = `FSS_CNT_W'(`FSS_WAKE_CYC),
   parameter logic [`FSS_CNT_W-1:0] OCP_CYC = `FSS_CNT_W'(`FSS_OCP_CYC)
)
(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // Controller side
   input wire logic sleep_ctl_low_in,
   input wire logic fault_indicator_low_in,
   output logic fault_indicator_low_o_out,
   output logic fault_indicator_low_oe_out,
   // Analog side
   input wire fss_pkg::fss_det_s det_in,
   output fss_pkg::fss_drv_s drv_out
);
   import fss_pkg::*;

   // Saturating counter step
   function automatic logic [`FSS_CNT_W-1:0] cnt_step(input logic [`FSS_CNT_W-1:0] c);
      begin
         cnt_step = (c == `FSS_CNT_MAX) ? c : c + `FSS_CNT_ONE;
      end
   endfunction

   // ************************************************************
   // Sleep input synchroniser
   // ************************************************************
   logic sleep_meta_r;
   logic sleep_sync_r;
   logic sleep_prev_r;
   logic sleep_meta_nxt;
   logic sleep_sync_nxt;
   logic sleep_prev_nxt;

   // Two stages, then a delayed copy for edge finding
   always_comb
   begin
      sleep_meta_nxt = sleep_ctl_low_in;
      sleep_sync_nxt = sleep_meta_r;
      sleep_prev_nxt = sleep_sync_r;
   end

   // Reset as if the pin were low; a high pin then shows one rise, with too little low time to clear
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         sleep_meta_r <= 1'b0;
         sleep_sync_r <= 1'b0;
         sleep_prev_r <= 1'b0;
      end
      else
      begin
         sleep_meta_r <= sleep_meta_nxt;
         sleep_sync_r <= sleep_sync_nxt;
         sleep_prev_r <= sleep_prev_nxt;
      end
   end

   // ************************************************************
   // Power state and low-time measurement
   // ************************************************************
   fss_state_e state_r;
   fss_state_e state_nxt;
   logic [`FSS_CNT_W-1:0] low_cnt_r;
   logic [`FSS_CNT_W-1:0] low_cnt_nxt;
   logic [`FSS_CNT_W-1:0] wake_cnt_r;
   logic [`FSS_CNT_W-1:0] wake_cnt_nxt;
   logic rise;
   logic clr;

   // Qualified release of the sleep input clears latched faults
   assign rise = sleep_sync_r & ~sleep_prev_r;
   assign clr = rise & (low_cnt_r > RST_MIN_CYC);

   // Low time counter, wake timer and state moves
   always_comb
   begin
      low_cnt_nxt = sleep_sync_r ? `FSS_CNT_ZERO : cnt_step(low_cnt_r);
      wake_cnt_nxt = wake_cnt_r;
      state_nxt = state_r;
      unique case (state_r)
         FSS_SLEEP:
         begin
            wake_cnt_nxt = `FSS_CNT_ZERO;
            if (sleep_sync_r)
            begin
               state_nxt = FSS_WAKE;
            end
         end
         FSS_WAKE:
         begin
            if (sleep_sync_r)
            begin
               wake_cnt_nxt = cnt_step(wake_cnt_r);
            end
            if (!sleep_sync_r && low_cnt_r >= SLEEP_ENTRY_CYC)
            begin
               state_nxt = FSS_SLEEP;
            end
            else if (wake_cnt_r >= WAKE_CYC - `FSS_CNT_ONE)
            begin
               state_nxt = FSS_ACTIVE;
            end
         end
         FSS_ACTIVE:
         begin
            // Pulses shorter than the entry delay leave the state alone
            if (!sleep_sync_r && low_cnt_r >= SLEEP_ENTRY_CYC)
            begin
               state_nxt = FSS_SLEEP;
            end
         end
         default:
         begin
            state_nxt = FSS_SLEEP;
         end
      endcase
   end

   // Reset starts the wake delay, as after power-up
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_r <= FSS_WAKE;
         low_cnt_r <= `FSS_CNT_ZERO;
         wake_cnt_r <= `FSS_CNT_ZERO;
      end
      else
      begin
         state_r <= state_nxt;
         low_cnt_r <= low_cnt_nxt;
         wake_cnt_r <= wake_cnt_nxt;
      end
   end

   // ************************************************************
   // Fault latches
   // ************************************************************
   logic [1:0] oc_r;
   logic [1:0] oc_nxt;
   logic ot_r;
   logic ot_nxt;
   logic [`FSS_CNT_W-1:0] oc_cnt_r [2];
   logic [`FSS_CNT_W-1:0] oc_cnt_nxt [2];

   // Filter each current limit; a new trip wins over a clear
   always_comb
   begin
      for (int b = 0; b < 2; b++)
      begin
         oc_cnt_nxt[b] = det_in.ilimit[b] ? cnt_step(oc_cnt_r[b]) : `FSS_CNT_ZERO;
         oc_nxt[b] = (oc_r[b] & ~clr & ~det_in.supply_low)
            | (det_in.ilimit[b] & (oc_cnt_r[b] >= OCP_CYC));
      end
      // Cooling alone does not release the latch
      ot_nxt = (ot_r & ~(clr & det_in.cool) & ~det_in.supply_low) | det_in.hot;
   end

   // Latches cleared at reset
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         oc_r <= 2'h0;
         ot_r <= 1'b0;
         oc_cnt_r[0] <= `FSS_CNT_ZERO;
         oc_cnt_r[1] <= `FSS_CNT_ZERO;
      end
      else
      begin
         oc_r <= oc_nxt;
         ot_r <= ot_nxt;
         oc_cnt_r[0] <= oc_cnt_nxt[0];
         oc_cnt_r[1] <= oc_cnt_nxt[1];
      end
   end

   // ************************************************************
   // Power stage controls and fault pin
   // ************************************************************
   fss_drv_s drv_r;
   fss_drv_s drv_nxt;
   logic fault_oe_r;
   logic fault_oe_nxt;
   logic awake;
   logic hot_any;

   assign awake = (state_r != FSS_SLEEP);
   assign hot_any = ot_r | det_in.hot;

   // Gate each control from state and faults
   always_comb
   begin
      for (int b = 0; b < 2; b++)
      begin
         drv_nxt.bridge_en[b] = sleep_sync_r & awake
            & ~det_in.supply_low
            & ~det_in.pump_low
            & ~hot_any
            & ~oc_r[b];
      end
      drv_nxt.pump_en = awake & ~det_in.supply_low & ~hot_any;
      drv_nxt.ldo_en = awake;
      drv_nxt.ready = (state_r == FSS_ACTIVE) & sleep_sync_r & ~det_in.supply_low;
      fault_oe_nxt = det_in.supply_low | det_in.pump_low | hot_any | (|oc_r);
   end

   // Everything off and the fault pin released at reset
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         drv_r <= '0;
         fault_oe_r <= 1'b0;
      end
      else
      begin
         drv_r <= drv_nxt;
         fault_oe_r <= fault_oe_nxt;
      end
   end

   // Open drain: only ever pulls low
   assign fault_indicator_low_o_out = 1'b0;
   assign fault_indicator_low_oe_out = fault_oe_r;
   assign drv_out = drv_r;

endmodule
